// *** inc/tpr_pkg.sv ***
package tpr_pkg;

    localparam int CLK_PERIOD_NS = 10;

    localparam int NUM_PINS       = 10;
    localparam int NUM_ROUTES     = 13;
    localparam int NUM_DED        = 5;
    localparam int SEL_W          = 4;
    localparam int ROUTES_PER_REG = 8;
    localparam int ADDR_W         = 8;

    localparam logic [ADDR_W-1:0] OFF_PIN_OE   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PIN_POL  = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PIN_DET  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_ROUTE_LO = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_ROUTE_HI = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STROBE   = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_ROUTED   = 8'h1C;

    localparam logic [SEL_W-1:0] SEL_NONE = 4'hF;

    localparam int CTL_W          = 7;
    localparam int CTL_SAMPLE_EN  = 0;
    localparam int CTL_SAMPLE_POL = 1;
    localparam int CTL_LATCH_LVL  = 2;
    localparam int CTL_HW_MODE    = 3;
    localparam int CTL_BASE_FAST  = 4;
    localparam int CTL_GO         = 5;
    localparam int CTL_PRETRIG    = 6;
    localparam logic [CTL_W-1:0] CTL_RESET = 7'h04;

    localparam int STAT_BUSY   = 16;
    localparam int STAT_SAMPLE = 17;

    localparam int SAMPLE_LEAD_NS   = 50;
    localparam int SAMPLE_LEAD_CYC  = (SAMPLE_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAMPLE_WIDTH_NS  = 400;
    localparam int SAMPLE_WIDTH_CYC = (SAMPLE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SMP_CNT_W        = 6;

    localparam int BASE_SLOW_NS  = 10000;
    localparam int BASE_FAST_NS  = 1200;
    localparam int SLOW_HALF_CYC = BASE_SLOW_NS / CLK_PERIOD_NS / 2;
    localparam int FAST_HALF_CYC = BASE_FAST_NS / CLK_PERIOD_NS / 2;
    localparam int BURST_PULSES  = 8;
    localparam int LAT_CNT_W     = 10;
    localparam int LAT_NUM_W     = 3;

    typedef enum logic [1:0] {SMP_IDLE, SMP_LEAD, SMP_PULSE} tpr_sample_e;
    typedef enum logic [1:0] {LAT_IDLE, LAT_LOW, LAT_HIGH} tpr_latch_e;

endpackage

// *** inc/tpr_pin_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface tpr_pin_if #(parameter int N = 10);
    logic [N-1:0] raw;
    logic [N-1:0] pol;
    logic [N-1:0] edge_mode;
    logic [N-1:0] level;
    logic [N-1:0] cond;

    modport cond_side (input raw, input pol, input edge_mode, output level, output cond);
    modport user_side (output raw, output pol, output edge_mode, input level, input cond);
endinterface

`default_nettype wire

// *** hdl/tpr_pin_cond.sv ***
`timescale 1ns/1ps
`default_nettype none

module tpr_pin_cond #(
    parameter int N = 10
) (
    input wire logic          sys_clk,
    input wire logic          rst,
    tpr_pin_if.cond_side      bus
);

    logic [N-1:0] sync1_r;
    logic [N-1:0] sync2_r;
    logic [N-1:0] prev_r;
    logic [N-1:0] prev_nxt;

    // Polarity is applied after the synchroniser, detection after polarity
    always_comb begin
        bus.level = sync2_r ^ bus.pol;
        prev_nxt  = bus.level;
        bus.cond  = (bus.edge_mode & bus.level & ~prev_r)
                  | (~bus.edge_mode & bus.level);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r  <= '0;
        end else begin
            sync1_r <= bus.raw;
            sync2_r <= sync1_r;
            prev_r  <= prev_nxt;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_chk
            a_edge_single: assert property (
                @(posedge sys_clk) disable iff (rst)
                bus.edge_mode[g] && bus.cond[g] ##1 bus.edge_mode[g] |-> !bus.cond[g]
            ) else $error("edge detect held longer than one cycle");

            a_level_path: assert property (
                @(posedge sys_clk) disable iff (rst)
                !bus.edge_mode[g] |-> bus.cond[g] == ($past(bus.raw[g], 2) ^ bus.pol[g])
            ) else $error("level path does not follow synchronised pin");
        end
    endgenerate

endmodule

`default_nettype wire

// *** hdl/tpr_router.sv ***
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Ten programmable function pins carry external timing control.
// - Each pin drives its own fixed internal timing signal, not selectable.
// - Five dedicated output pins carry the remaining timing signals.
// - Thirteen routed timing signals each pick their source pin independently.
// - A per-pin driver enable puts the assigned signal on the connector.
// - Each input pin has its own edge or level detection and polarity.
// - Level mode adds no pulse-width limits of its own.
// - Acquisition supports posttriggered and pretriggered sequencing modes.
// - Sample-taken strobe is output only, leading edge 50-100 ns after conversion.
// - Sample-taken strobe polarity is software selectable, normally rising.
// - Sample-taken pulse lasts 400-500 ns and is driven only when enabled.
// - Latch strobe is output only: single level or eight-pulse burst.
// - In single-pulse mode the latch strobe follows a software bit.
// - Burst timing uses a selectable 10 us or 1.2 us base clock.
// - Pin drivers are high impedance after startup.
// - Scan gate input may use level or edge, either polarity.
module tpr_router #(
    parameter int NUM_PINS   = tpr_pkg::NUM_PINS,
    parameter int NUM_ROUTES = tpr_pkg::NUM_ROUTES,
    parameter int NUM_DED    = tpr_pkg::NUM_DED
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [tpr_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic [NUM_PINS-1:0]       pin_in,
    output logic      [NUM_PINS-1:0]       pin_out,
    output logic      [NUM_PINS-1:0]       pin_oe_n,
    input  wire logic [NUM_PINS-1:0]       pin_timing,
    input  wire logic [NUM_DED-1:0]        dedicated_timing,
    output logic      [NUM_DED-1:0]        dedicated_out,
    output logic      [NUM_ROUTES-1:0]     routed_timing,
    input  wire logic                      conv_start,
    output logic                           sample_taken_strobe,
    output logic                           sample_taken_oe_n,
    output logic                           external_latch_strobe,
    output logic                           acq_pretrig_mode
);

    localparam int A_LEAD      = tpr_pkg::SAMPLE_LEAD_CYC;
    localparam int A_WID_M1    = tpr_pkg::SAMPLE_WIDTH_CYC - 1;
    localparam int A_FAST_HALF = tpr_pkg::FAST_HALF_CYC;

    logic [NUM_PINS-1:0]                    oe_r;
    logic [NUM_PINS-1:0]                    oe_nxt;
    logic [NUM_PINS-1:0]                    pol_r;
    logic [NUM_PINS-1:0]                    pol_nxt;
    logic [NUM_PINS-1:0]                    det_r;
    logic [NUM_PINS-1:0]                    det_nxt;
    logic [NUM_ROUTES-1:0][tpr_pkg::SEL_W-1:0] sel_r;
    logic [NUM_ROUTES-1:0][tpr_pkg::SEL_W-1:0] sel_nxt;
    logic [tpr_pkg::CTL_W-1:0]              ctrl_r;
    logic [tpr_pkg::CTL_W-1:0]              ctrl_nxt;
    logic [31:0]                            prdata_r;
    logic [31:0]                            prdata_nxt;
    logic [31:0]                            rd_word;
    logic                                   go;
    logic                                   acc_wr;
    logic [NUM_ROUTES-1:0]                  routed_r;
    logic [NUM_ROUTES-1:0]                  routed_nxt;
    logic [NUM_PINS-1:0]                    pin_out_r;
    logic [NUM_DED-1:0]                     ded_out_r;

    tpr_pkg::tpr_sample_e                   smp_st_r;
    tpr_pkg::tpr_sample_e                   smp_st_nxt;
    logic [tpr_pkg::SMP_CNT_W-1:0]          smp_cnt_r;
    logic [tpr_pkg::SMP_CNT_W-1:0]          smp_cnt_nxt;
    logic                                   smp_out_r;
    logic                                   smp_out_nxt;

    tpr_pkg::tpr_latch_e                    lat_st_r;
    tpr_pkg::tpr_latch_e                    lat_st_nxt;
    logic [tpr_pkg::LAT_CNT_W-1:0]          lat_cnt_r;
    logic [tpr_pkg::LAT_CNT_W-1:0]          lat_cnt_nxt;
    logic [tpr_pkg::LAT_CNT_W-1:0]          lat_half;
    logic [tpr_pkg::LAT_NUM_W-1:0]          lat_num_r;
    logic [tpr_pkg::LAT_NUM_W-1:0]          lat_num_nxt;
    logic                                   lat_out_r;
    logic                                   lat_out_nxt;
    logic                                   lat_busy;

    logic                                   a_oe_touched_r;
    logic [3:0]                             a_fall_cnt_r;

    tpr_pin_if #(.N(NUM_PINS)) pins ();

    function automatic logic route_pick(input logic [NUM_PINS-1:0] cond,
                                        input logic [tpr_pkg::SEL_W-1:0] sel);
        if (sel < tpr_pkg::SEL_W'(NUM_PINS)) begin
            return cond[sel];
        end
        return 1'b0;
    endfunction

    function automatic logic reg_mapped(input logic [tpr_pkg::ADDR_W-1:0] a);
        return a == tpr_pkg::OFF_PIN_OE   || a == tpr_pkg::OFF_PIN_POL ||
               a == tpr_pkg::OFF_PIN_DET  || a == tpr_pkg::OFF_ROUTE_LO ||
               a == tpr_pkg::OFF_ROUTE_HI || a == tpr_pkg::OFF_STROBE ||
               a == tpr_pkg::OFF_STATUS   || a == tpr_pkg::OFF_ROUTED;
    endfunction

    // Every pin shares one conditioner bank; routes only select its results
    assign pins.raw       = pin_in;
    assign pins.pol       = pol_r;
    assign pins.edge_mode = det_r;

    tpr_pin_cond #(.N(NUM_PINS)) u_cond (
        .sys_clk (sys_clk),
        .rst     (rst),
        .bus     (pins)
    );

    // Zero wait states: read data is captured in the setup cycle
    assign acc_wr  = psel & penable & pwrite;
    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~reg_mapped(paddr);
    assign prdata  = prdata_r;

    always_comb begin
        rd_word = '0;
        case (paddr)
            tpr_pkg::OFF_PIN_OE:   rd_word[NUM_PINS-1:0] = oe_r;
            tpr_pkg::OFF_PIN_POL:  rd_word[NUM_PINS-1:0] = pol_r;
            tpr_pkg::OFF_PIN_DET:  rd_word[NUM_PINS-1:0] = det_r;
            tpr_pkg::OFF_ROUTE_LO: begin
                for (int i = 0; i < tpr_pkg::ROUTES_PER_REG; i++) begin
                    rd_word[i*tpr_pkg::SEL_W +: tpr_pkg::SEL_W] = sel_r[i];
                end
            end
            tpr_pkg::OFF_ROUTE_HI: begin
                for (int i = tpr_pkg::ROUTES_PER_REG; i < NUM_ROUTES; i++) begin
                    rd_word[(i-tpr_pkg::ROUTES_PER_REG)*tpr_pkg::SEL_W +: tpr_pkg::SEL_W] = sel_r[i];
                end
            end
            tpr_pkg::OFF_STROBE:   rd_word[tpr_pkg::CTL_W-1:0] = ctrl_r;
            tpr_pkg::OFF_STATUS: begin
                rd_word[NUM_PINS-1:0]        = pins.level;
                rd_word[tpr_pkg::STAT_BUSY]   = lat_busy;
                rd_word[tpr_pkg::STAT_SAMPLE] = smp_st_r == tpr_pkg::SMP_PULSE;
            end
            tpr_pkg::OFF_ROUTED:   rd_word[NUM_ROUTES-1:0] = routed_r;
            default:               rd_word = '0;
        endcase
    end

    always_comb begin
        oe_nxt     = oe_r;
        pol_nxt    = pol_r;
        det_nxt    = det_r;
        sel_nxt    = sel_r;
        ctrl_nxt   = ctrl_r;
        go         = 1'b0;
        prdata_nxt = (psel & ~penable & ~pwrite) ? rd_word : prdata_r;
        if (acc_wr) begin
            case (paddr)
                tpr_pkg::OFF_PIN_OE:   oe_nxt  = pwdata[NUM_PINS-1:0];
                tpr_pkg::OFF_PIN_POL:  pol_nxt = pwdata[NUM_PINS-1:0];
                tpr_pkg::OFF_PIN_DET:  det_nxt = pwdata[NUM_PINS-1:0];
                tpr_pkg::OFF_ROUTE_LO: begin
                    for (int i = 0; i < tpr_pkg::ROUTES_PER_REG; i++) begin
                        sel_nxt[i] = pwdata[i*tpr_pkg::SEL_W +: tpr_pkg::SEL_W];
                    end
                end
                tpr_pkg::OFF_ROUTE_HI: begin
                    for (int i = tpr_pkg::ROUTES_PER_REG; i < NUM_ROUTES; i++) begin
                        sel_nxt[i] = pwdata[(i-tpr_pkg::ROUTES_PER_REG)*tpr_pkg::SEL_W +: tpr_pkg::SEL_W];
                    end
                end
                tpr_pkg::OFF_STROBE: begin
                    ctrl_nxt                 = pwdata[tpr_pkg::CTL_W-1:0];
                    ctrl_nxt[tpr_pkg::CTL_GO] = 1'b0;
                    go                       = pwdata[tpr_pkg::CTL_GO];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            oe_r     <= '0;
            pol_r    <= '0;
            det_r    <= '0;
            sel_r    <= {NUM_ROUTES{tpr_pkg::SEL_NONE}};
            ctrl_r   <= tpr_pkg::CTL_RESET;
            prdata_r <= '0;
        end else begin
            oe_r     <= oe_nxt;
            pol_r    <= pol_nxt;
            det_r    <= det_nxt;
            sel_r    <= sel_nxt;
            ctrl_r   <= ctrl_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_ROUTES; g++) begin : g_route
            assign routed_nxt[g] = route_pick(pins.cond, sel_r[g]);
        end
    endgenerate

    // Fixed per-pin signals: no selector, so a pin can only show its own source
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            routed_r  <= '0;
            pin_out_r <= '0;
            ded_out_r <= '0;
        end else begin
            routed_r  <= routed_nxt;
            pin_out_r <= pin_timing;
            ded_out_r <= dedicated_timing;
        end
    end

    assign routed_timing    = routed_r;
    assign pin_out          = pin_out_r;
    assign pin_oe_n         = ~oe_r;
    assign dedicated_out    = ded_out_r;
    assign acq_pretrig_mode = ctrl_r[tpr_pkg::CTL_PRETRIG];

    // Conversions during a running strobe are dropped; the ADC cannot restart that fast
    always_comb begin
        smp_st_nxt  = smp_st_r;
        smp_cnt_nxt = smp_cnt_r;
        unique case (smp_st_r)
            tpr_pkg::SMP_IDLE: begin
                if (conv_start) begin
                    smp_st_nxt  = tpr_pkg::SMP_LEAD;
                    smp_cnt_nxt = tpr_pkg::SMP_CNT_W'(tpr_pkg::SAMPLE_LEAD_CYC - 2);
                end
            end
            tpr_pkg::SMP_LEAD: begin
                if (smp_cnt_r == '0) begin
                    smp_st_nxt  = tpr_pkg::SMP_PULSE;
                    smp_cnt_nxt = tpr_pkg::SMP_CNT_W'(tpr_pkg::SAMPLE_WIDTH_CYC - 1);
                end else begin
                    smp_cnt_nxt = smp_cnt_r - 1'b1;
                end
            end
            tpr_pkg::SMP_PULSE: begin
                if (smp_cnt_r == '0) begin
                    smp_st_nxt = tpr_pkg::SMP_IDLE;
                end else begin
                    smp_cnt_nxt = smp_cnt_r - 1'b1;
                end
            end
        endcase
        smp_out_nxt = (smp_st_nxt == tpr_pkg::SMP_PULSE) ^ ctrl_r[tpr_pkg::CTL_SAMPLE_POL];
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            smp_st_r  <= tpr_pkg::SMP_IDLE;
            smp_cnt_r <= '0;
            smp_out_r <= 1'b0;
        end else begin
            smp_st_r  <= smp_st_nxt;
            smp_cnt_r <= smp_cnt_nxt;
            smp_out_r <= smp_out_nxt;
        end
    end

    assign sample_taken_strobe = smp_out_r;
    assign sample_taken_oe_n   = ~ctrl_r[tpr_pkg::CTL_SAMPLE_EN];

    // Base clock is read at each counter reload; changing it mid-burst takes effect from the next half period
    assign lat_half = ctrl_r[tpr_pkg::CTL_BASE_FAST] ?
                      tpr_pkg::LAT_CNT_W'(tpr_pkg::FAST_HALF_CYC) :
                      tpr_pkg::LAT_CNT_W'(tpr_pkg::SLOW_HALF_CYC);
    assign lat_busy = lat_st_r != tpr_pkg::LAT_IDLE;

    always_comb begin
        lat_st_nxt  = lat_st_r;
        lat_cnt_nxt = lat_cnt_r;
        lat_num_nxt = lat_num_r;
        unique case (lat_st_r)
            tpr_pkg::LAT_IDLE: begin
                if (go && ctrl_r[tpr_pkg::CTL_HW_MODE]) begin
                    lat_st_nxt  = tpr_pkg::LAT_LOW;
                    lat_cnt_nxt = lat_half - 1'b1;
                    lat_num_nxt = '0;
                end
            end
            tpr_pkg::LAT_LOW: begin
                if (lat_cnt_r == '0) begin
                    lat_st_nxt  = tpr_pkg::LAT_HIGH;
                    lat_cnt_nxt = lat_half - 1'b1;
                end else begin
                    lat_cnt_nxt = lat_cnt_r - 1'b1;
                end
            end
            tpr_pkg::LAT_HIGH: begin
                if (lat_cnt_r != '0) begin
                    lat_cnt_nxt = lat_cnt_r - 1'b1;
                end else if (lat_num_r == tpr_pkg::LAT_NUM_W'(tpr_pkg::BURST_PULSES - 1)) begin
                    lat_st_nxt = tpr_pkg::LAT_IDLE;
                end else begin
                    lat_st_nxt  = tpr_pkg::LAT_LOW;
                    lat_cnt_nxt = lat_half - 1'b1;
                    lat_num_nxt = lat_num_r + 1'b1;
                end
            end
        endcase
        unique case (lat_st_nxt)
            tpr_pkg::LAT_LOW:  lat_out_nxt = 1'b0;
            tpr_pkg::LAT_HIGH: lat_out_nxt = 1'b1;
            default:           lat_out_nxt = ctrl_nxt[tpr_pkg::CTL_HW_MODE] |
                                             ctrl_nxt[tpr_pkg::CTL_LATCH_LVL];
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lat_st_r  <= tpr_pkg::LAT_IDLE;
            lat_cnt_r <= '0;
            lat_num_r <= '0;
            lat_out_r <= 1'b1;
        end else begin
            lat_st_r  <= lat_st_nxt;
            lat_cnt_r <= lat_cnt_nxt;
            lat_num_r <= lat_num_nxt;
            lat_out_r <= lat_out_nxt;
        end
    end

    assign external_latch_strobe = lat_out_r;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            a_oe_touched_r <= 1'b0;
            a_fall_cnt_r   <= '0;
        end else begin
            if (acc_wr && paddr == tpr_pkg::OFF_PIN_OE) begin
                a_oe_touched_r <= 1'b1;
            end
            if (lat_out_r && !lat_out_nxt) begin
                a_fall_cnt_r <= a_fall_cnt_r + 1'b1;
            end else if (!lat_busy) begin
                a_fall_cnt_r <= '0;
            end
        end
    end

    a_pin_drive: assert property (
        @(posedge sys_clk) disable iff (rst)
        1'b1 |=> pin_out == $past(pin_timing)
    ) else $error("pin output is not its own timing signal");

    a_oe_write: assert property (
        @(posedge sys_clk) disable iff (rst)
        acc_wr && paddr == tpr_pkg::OFF_PIN_OE |=> pin_oe_n == ~$past(pwdata[NUM_PINS-1:0])
    ) else $error("pin driver enable does not follow write");

    a_startup_hiz: assert property (
        @(posedge sys_clk) disable iff (rst)
        !a_oe_touched_r |-> &pin_oe_n
    ) else $error("pin driven before software enabled it");

    a_sample_lead: assert property (
        @(posedge sys_clk) disable iff (rst)
        smp_st_r == tpr_pkg::SMP_IDLE && conv_start |-> ##A_LEAD smp_st_r == tpr_pkg::SMP_PULSE
    ) else $error("sample strobe lead time wrong");

    a_sample_width: assert property (
        @(posedge sys_clk) disable iff (rst)
        $rose(smp_st_r == tpr_pkg::SMP_PULSE) |->
            ##A_WID_M1 smp_st_r == tpr_pkg::SMP_PULSE ##1 smp_st_r != tpr_pkg::SMP_PULSE
    ) else $error("sample strobe width wrong");

    a_sample_pol: assert property (
        @(posedge sys_clk) disable iff (rst)
        $rose(smp_st_r == tpr_pkg::SMP_PULSE) |->
            sample_taken_strobe == !$past(ctrl_r[tpr_pkg::CTL_SAMPLE_POL])
    ) else $error("sample strobe active level wrong");

    a_sample_oe: assert property (
        @(posedge sys_clk) disable iff (rst)
        acc_wr && paddr == tpr_pkg::OFF_STROBE && !pwdata[tpr_pkg::CTL_SAMPLE_EN] |=> sample_taken_oe_n
    ) else $error("sample strobe driven while disabled");

    a_latch_idle: assert property (
        @(posedge sys_clk) disable iff (rst)
        lat_st_r == tpr_pkg::LAT_IDLE |->
            external_latch_strobe == (ctrl_r[tpr_pkg::CTL_HW_MODE] | ctrl_r[tpr_pkg::CTL_LATCH_LVL])
    ) else $error("latch strobe idle level wrong");

    a_latch_count: assert property (
        @(posedge sys_clk) disable iff (rst)
        $fell(lat_busy) |-> a_fall_cnt_r == 4'h8
    ) else $error("latch burst pulse count wrong");

    a_latch_fast: assert property (
        @(posedge sys_clk) disable iff (rst)
        lat_st_r == tpr_pkg::LAT_IDLE && go && ctrl_r[tpr_pkg::CTL_HW_MODE] &&
        ctrl_r[tpr_pkg::CTL_BASE_FAST] && ctrl_nxt[tpr_pkg::CTL_BASE_FAST] |->
            ##A_FAST_HALF lat_st_r == tpr_pkg::LAT_LOW ##1 lat_st_r == tpr_pkg::LAT_HIGH
    ) else $error("fast burst half period wrong");

endmodule

`default_nettype wire

// *** tb/tpr_ext_src.sv ***
`timescale 1ns/1ps
`default_nettype none

module tpr_ext_src (
    input  wire logic [9:0] drive,
    input  wire logic [9:0] pin_oe_n,
    input  wire logic [9:0] pin_out,
    output logic      [9:0] pin_in
);
    // Outside source backs off wherever the card drives; levels are held many cycles
    assign pin_in = (drive & pin_oe_n) | (pin_out & ~pin_oe_n);
endmodule

`default_nettype wire

// *** tb/tb_timing_pin_router_strobes.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_timing_pin_router_strobes;
    logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, e, conv_start;
    logic        smp, smp_oe_n, lat, pretrig, p;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [9:0]  drive, pin_in, pin_out, pin_oe_n, pin_timing;
    logic [4:0]  ded_in, ded_out;
    logic [12:0] routed;
    int          n_errors = 0, n_tests = 0, cyc = 0, cnt, n_low;

    tpr_router i_tpr_router (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_timing(pin_timing), .dedicated_timing(ded_in), .dedicated_out(ded_out),
        .routed_timing(routed), .conv_start(conv_start), .sample_taken_strobe(smp),
        .sample_taken_oe_n(smp_oe_n), .external_latch_strobe(lat), .acq_pretrig_mode(pretrig));
    tpr_ext_src i_tpr_ext_src (.drive(drive), .pin_oe_n(pin_oe_n), .pin_out(pin_out), .pin_in(pin_in));

    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end

    task end_of_test;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Whole run is about 9300 cycles, most of it the slow burst
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            n_errors++;
            end_of_test();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    // Falls and low cycles tell the pulse count and the base clock apart
    task burst(input int len, input int lows);
        cnt = 0;
        n_low = 0;
        p = 1;
        repeat (len) begin
            @(posedge sys_clk);
            if (p === 1'b1 && lat === 1'b0) cnt++;
            if (lat === 1'b0) n_low++;
            p = lat;
        end
        chk(cnt, 8);
        chk(n_low, lows);
        chk(lat, 1'b1);
    endtask

    initial begin
        rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; conv_start = 0;
        drive = 0; pin_timing = 10'h2A5; ded_in = 5'h15;
        repeat (10) @(posedge sys_clk);
        rst <= 0;
        @(posedge sys_clk);
        chk(pin_oe_n, 10'h3FF);
        chk(lat, 1'b1);
        chk(pretrig, 1'b0);
        apb(0, tpr_pkg::OFF_STROBE, 0);
        chk(r, 32'h4);
        $display("test reset done");
        apb(1, tpr_pkg::OFF_PIN_OE, 32'h0C3);
        @(posedge sys_clk);
        chk(pin_oe_n, 10'h33C);
        chk(pin_out, 10'h2A5);
        chk(ded_out, 5'h15);
        apb(0, 8'h20, 0);
        chk({r[0], e}, 2'b01);
        $display("test drivers done");
        apb(1, tpr_pkg::OFF_ROUTE_LO, 32'hFFFFFF43);
        apb(1, tpr_pkg::OFF_PIN_DET, 32'h010);
        drive <= 10'h018;
        cnt = 0;
        repeat (5) begin
            @(posedge sys_clk);
            if (routed[1] === 1'b1) cnt++;
        end
        chk(cnt, 1);
        chk(routed[1:0], 2'b01);
        apb(1, tpr_pkg::OFF_PIN_POL, 32'h008);
        repeat (5) @(posedge sys_clk);
        chk(routed[0], 1'b0);
        $display("test routing done");
        apb(1, tpr_pkg::OFF_STROBE, 32'h5);
        @(posedge sys_clk);
        chk(smp_oe_n, 1'b0);
        conv_start <= 1;
        @(posedge sys_clk);
        conv_start <= 0;
        cnt = 0;
        repeat (60) begin
            @(posedge sys_clk);
            if (smp === 1'b1) cnt++;
        end
        chk(cnt, 40);
        apb(1, tpr_pkg::OFF_STROBE, 32'h7);
        repeat (2) @(posedge sys_clk);
        chk(smp, 1'b1);
        $display("test sample strobe done");
        apb(1, tpr_pkg::OFF_STROBE, 0);
        repeat (2) @(posedge sys_clk);
        chk(lat, 1'b0);
        apb(1, tpr_pkg::OFF_STROBE, 32'h4C);
        @(posedge sys_clk);
        chk(pretrig, 1'b1);
        apb(1, tpr_pkg::OFF_STROBE, 32'h5C);
        apb(1, tpr_pkg::OFF_STROBE, 32'h7C);
        burst(1100, 480);
        apb(1, tpr_pkg::OFF_STROBE, 32'h4C);
        apb(1, tpr_pkg::OFF_STROBE, 32'h6C);
        burst(8100, 4000);
        $display("test latch strobe done");
        end_of_test();
    end
endmodule

`default_nettype wire
